// ===== rtl/trb_regs.vh
`ifndef TRB_REGS_VH
`define TRB_REGS_VH
// read and write byte counts
`define TRB_NUM_WR_BYTES 5
`define TRB_NUM_RD_BYTES 5
`define TRB_RD_BITS 40
// fifth write byte fields
`define TRB_WR5_REF_BIT 7
`define TRB_WR5_DEEMPH_BIT 6
// first read byte fields
`define TRB_RD1_DONE_BIT 7
`define TRB_RD1_EDGE_BIT 6
// third read byte fields
`define TRB_RD3_STEREO_BIT 7
// fourth read byte fields
`define TRB_RD4_ZERO_BIT 0
// reset values of the fifth write byte fields
`define TRB_REF_RST 1'h0
`define TRB_DEEMPH_RST 1'h0
// chip identification value (arbitrary value)
`define TRB_CHIP_IDENT 3'h5
// reserved read byte value
`define TRB_RESERVED_BYTE 8'h00
`endif

// ===== rtl/trb_sync.v
`default_nettype none
// three-stage synchroniser; level changes once stages two and three agree
module trb_sync (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire clk_en_i,
  // asynchronous input and filtered level
  input wire async_i,
  output reg level_o
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  // shift chain; only s2 reads s1
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= 1'h0;
      s2_q <= 1'h0;
      s3_q <= 1'h0;
      level_o <= 1'h0;
    end else if (clk_en_i) begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_o <= s3_q;
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/trb_tuner_regs.v
// Notes on behaviour
// - bit 7 of the fifth written byte turns the 6.5 MHz synthesizer reference on when one and off when zero.
// - bit 6 of the fifth written byte selects 75 us de-emphasis when one and 50 us when zero.
// - the six low bits of the fifth written byte are ignored.
// - bit 7 of read byte one is the search-done flag.
// - bit 6 of read byte one is the band-edge flag.
// - the 14-bit divider word reads back, upper six bits in byte one, lower eight in byte two.
// - bit 7 of read byte three shows stereo when one and mono when zero.
// - the low seven bits of read byte three carry the IF counter result.
// - the upper four bits of read byte four carry the signal level code.
// - bits 3 to 1 of read byte four carry the fixed chip identification value.
// - bit 0 of read byte four always reads zero.
// - read byte five always reads all zeros.
// - read data shifts out on the falling bus clock edge, msb of byte one first, sampled by host on rising edge.
// - after reset audio is muted; the host writes all five bytes to initialise.
`include "trb_regs.vh"
`default_nettype none
module trb_tuner_regs (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire clk_en_i,
  // three-wire bus pins
  input wire bus_clk_i,
  input wire bus_wr_rd_i,
  input wire bus_data_i,
  output reg bus_data_o,
  output reg bus_data_oe_o,
  // tuner status inputs
  input wire search_done_flag_i,
  input wire band_edge_flag_i,
  input wire [13:0] divider_word_i,
  input wire stereo_i,
  input wire [6:0] if_count_i,
  input wire [3:0] signal_level_code_i,
  // configuration outputs
  output reg synth_ref_6m5_enable_o,
  output reg deemphasis_select_o,
  output reg mute_o,
  output reg [7:0] wr_byte1_o,
  output reg [7:0] wr_byte2_o,
  output reg [7:0] wr_byte3_o,
  output reg [7:0] wr_byte4_o,
  output reg wr_done_o
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WRITE = 2'h1;
  localparam ST_READ = 2'h2;

  wire clk_s;
  wire wr_rd_s;
  wire data_s;
  reg clk_prev_q;
  reg wr_rd_prev_q;
  reg [1:0] state_q;
  reg [5:0] bit_cnt_q;
  reg [7:0] shift_q;
  reg [39:0] snap_q;
  reg [2:0] byte_idx_q;
  wire clk_rise;
  wire clk_fall;
  wire wr_rise;
  wire wr_fall;
  wire [39:0] status_img;
  // byte as it completes on a rising bus clock
  wire [7:0] byte_in;
  // read image split per byte
  wire [7:0] rd_byte1;
  wire [7:0] rd_byte2;
  wire [7:0] rd_byte3;
  wire [7:0] rd_byte4;
  wire [7:0] rd_byte5;

  // byte formed by the seven bits held plus the bit arriving now
  function [7:0] full_byte;
    input [6:0] held;
    input bit_in;
    begin
      full_byte = {held, bit_in};
    end
  endfunction

  // one synchroniser per bus pin
  trb_sync u_sync_clk (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .async_i(bus_clk_i),
    .level_o(clk_s)
  );
  trb_sync u_sync_wr (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .async_i(bus_wr_rd_i),
    .level_o(wr_rd_s)
  );
  trb_sync u_sync_data (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .async_i(bus_data_i),
    .level_o(data_s)
  );

  // edge detection on filtered levels
  assign clk_rise = clk_s & ~clk_prev_q;
  assign clk_fall = ~clk_s & clk_prev_q;
  assign wr_rise = wr_rd_s & ~wr_rd_prev_q;
  assign wr_fall = ~wr_rd_s & wr_rd_prev_q;

  // read image, five bytes msb first
  assign rd_byte1 = {search_done_flag_i, band_edge_flag_i, divider_word_i[13:8]};
  assign rd_byte2 = divider_word_i[7:0];
  assign rd_byte3 = {stereo_i, if_count_i};
  assign rd_byte4 = {signal_level_code_i, `TRB_CHIP_IDENT, 1'h0};
  assign rd_byte5 = `TRB_RESERVED_BYTE;
  assign status_img = {rd_byte1, rd_byte2, rd_byte3, rd_byte4, rd_byte5};

  // incoming write byte
  assign byte_in = full_byte(shift_q[6:0], data_s);

  // previous filtered levels for edge strobes
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_prev_q <= 1'h0;
      wr_rd_prev_q <= 1'h0;
    end else if (clk_en_i) begin
      clk_prev_q <= clk_s;
      wr_rd_prev_q <= wr_rd_s;
    end
  end

  // bus transfer engine
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 6'h00;
      shift_q <= 8'h00;
      snap_q <= 40'h0000000000;
      byte_idx_q <= 3'h0;
      bus_data_o <= 1'h0;
      bus_data_oe_o <= 1'h0;
      synth_ref_6m5_enable_o <= `TRB_REF_RST;
      deemphasis_select_o <= `TRB_DEEMPH_RST;
      mute_o <= 1'h1;
      wr_byte1_o <= 8'h80;
      wr_byte2_o <= 8'h00;
      wr_byte3_o <= 8'h00;
      wr_byte4_o <= 8'h00;
      wr_done_o <= 1'h0;
    end else if (clk_en_i) begin
      wr_done_o <= 1'h0;
      if (wr_rise) begin
        // write frame opens
        state_q <= ST_WRITE;
        bit_cnt_q <= 6'h00;
        byte_idx_q <= 3'h0;
        bus_data_oe_o <= 1'h0;
      end else if (wr_fall) begin
        // read frame opens: snapshot and present msb at once
        state_q <= ST_READ;
        snap_q <= {status_img[38:0], 1'h0};
        bus_data_o <= status_img[39];
        bus_data_oe_o <= 1'h1;
        bit_cnt_q <= 6'h01;
      end else begin
        case (state_q)
          ST_WRITE: begin
            if (clk_rise) begin
              shift_q <= byte_in;
              if (bit_cnt_q[2:0] == 3'h7) begin
                // byte complete; stored in arrival order
                case (byte_idx_q)
                  3'h0: begin
                    wr_byte1_o <= byte_in;
                    mute_o <= byte_in[7];
                  end
                  3'h1: begin
                    wr_byte2_o <= byte_in;
                    wr_done_o <= 1'h1;
                  end
                  3'h2: wr_byte3_o <= byte_in;
                  3'h3: wr_byte4_o <= byte_in;
                  3'h4: begin
                    synth_ref_6m5_enable_o <= byte_in[`TRB_WR5_REF_BIT];
                    deemphasis_select_o <= byte_in[`TRB_WR5_DEEMPH_BIT];
                    // low six bits dropped
                  end
                  default: begin
                  end
                endcase
                if (byte_idx_q != 3'h5) begin
                  byte_idx_q <= byte_idx_q + 3'h1;
                end
              end
              bit_cnt_q <= bit_cnt_q + 6'h01;
            end
          end
          ST_READ: begin
            if (clk_fall) begin
              // next bit on falling edge; zero after byte five
              bus_data_o <= snap_q[39];
              snap_q <= {snap_q[38:0], 1'h0};
              if (bit_cnt_q != 6'h28) begin
                bit_cnt_q <= bit_cnt_q + 6'h01;
              end
            end
          end
          default: begin
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/test_tuner_readback_and_config_bytes.sv
`default_nettype none
`include "trb_regs.vh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module test_tuner_readback_and_config_bytes;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk_i, rst_n_i, clk_en_i, st_done, st_band, st_stereo;
  logic [13:0] st_div;
  logic [6:0] st_ifc;
  logic [3:0] st_lvl;
  logic [39:0] rd;
  wire bus_clk_i, bus_wr_rd_i, bus_data_i, bus_data_o, oe, ref_o, dem_o, mute_o;
  wire [7:0] wb1, wb2, wb3, wb4;
  wire done_w;
  int n_done = 0;
  int n_errors = 0;
  int samples_checked = 0;
  // device and host
  trb_tuner_regs dut_u (.sys_clk_i, .rst_n_i, .clk_en_i, .bus_clk_i, .bus_wr_rd_i, .bus_data_i, .bus_data_o,
    .bus_data_oe_o(oe), .search_done_flag_i(st_done), .band_edge_flag_i(st_band), .divider_word_i(st_div),
    .stereo_i(st_stereo), .if_count_i(st_ifc), .signal_level_code_i(st_lvl), .synth_ref_6m5_enable_o(ref_o),
    .deemphasis_select_o(dem_o), .mute_o, .wr_byte1_o(wb1), .wr_byte2_o(wb2), .wr_byte3_o(wb3),
    .wr_byte4_o(wb4), .wr_done_o(done_w));
  // count new-tuning pulses
  always @(posedge sys_clk_i) if (done_w === 1'b1) n_done++;
  trb_host host_u (.clk_o(bus_clk_i), .wr_rd_o(bus_wr_rd_i), .data_o(bus_data_i), .dev_data_i(bus_data_o));
  // system clock
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic summarize;
    if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // full write, fifth byte varied
  task automatic t_cfg(input logic [7:0] b5);
    int d0;
    d0 = n_done;
    host_u.put({8'h3A, 8'h5C, 8'h96, 8'h21, b5}, 5);
    `CHK(n_done - d0, 1)
    `CHK(ref_o, b5[7])
    `CHK(dem_o, b5[6])
    `CHK({mute_o, wb1, wb2, wb3, wb4}, 33'h03A5C9621)
  endtask
  // write stopped after two bytes leaves the rest alone
  task automatic t_partial;
    host_u.put({8'h81, 8'h02, 24'h000000}, 2);
    `CHK({mute_o, wb1, wb2, wb3, ref_o, dem_o}, 27'h6040A59)
  endtask
  // read image, status disturbed mid-transfer
  task automatic t_read(input logic [2:0] f, input logic [13:0] d, input logic [6:0] ic, input logic [3:0] lv);
    @(posedge sys_clk_i);
    {st_done, st_band, st_stereo, st_div, st_ifc, st_lvl} <= {f, d, ic, lv};
    fork
      begin
        #3000;
        @(posedge sys_clk_i);
        st_div <= ~d;
      end
    join_none
    host_u.get(rd);
    `CHK(rd, {f[2:1], d, f[0], ic, lv, `TRB_CHIP_IDENT, 1'b0, 8'h00})
    `CHK(oe, 1'b1)
    #200;
    `CHK(oe, 1'b0)
  endtask
  // watchdog
  initial begin
    #300us;
    n_errors++;
    summarize;
  end
  // main sequence
  initial begin
    rst_n_i = 1'b0;
    clk_en_i = 1'b1;
    {st_done, st_band, st_stereo, st_div, st_ifc, st_lvl} = 28'h0000000;
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (10) @(posedge sys_clk_i);
    `CHK({mute_o, wb1, ref_o, dem_o}, 11'h600)
    t_cfg(8'hBF);
    t_cfg(8'h00);
    t_cfg(8'h7F);
    t_partial;
    t_read(3'b111, 14'h2ABC, 7'h55, 4'hA);
    t_read(3'b100, 14'h1543, 7'h2A, 4'h5);
    summarize;
  end
endmodule
`default_nettype wire

// ===== tb/trb_host.sv
`default_nettype none
module trb_host (
  // bus pins toward the device
  output logic clk_o,
  output logic wr_rd_o,
  output logic data_o,
  input wire logic dev_data_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle bus with clock parked low
  initial begin
    clk_o = 1'b0;
    wr_rd_o = 1'b0;
    data_o = 1'b0;
  end
  // write n bytes in order, msb first, data moved while clock low
  task automatic put(input logic [39:0] v, input int n);
    wr_rd_o <= 1'b0;
    #1000 wr_rd_o <= 1'b1;
    for (int i = 0; i < n * 8; i++) begin
      #40 data_o <= v[39 - i];
      #40 clk_o <= 1'b1;
      #80 clk_o <= 1'b0;
    end
    #80 data_o <= ~data_o;
    wr_rd_o <= 1'b0;
  endtask
  // read all forty bits, sampled on the rising clock
  task automatic get(output logic [39:0] v);
    wr_rd_o <= 1'b1;
    #1000 wr_rd_o <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      #80 clk_o <= 1'b1;
      #1 v[39 - i] = dev_data_i;
      #79 clk_o <= 1'b0;
    end
    #80 wr_rd_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== tb/trb_tuner_regs_properties.sv
`default_nettype none
module trb_props (
  // clock, reset and bus pins
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic bus_clk_i,
  input wire logic bus_wr_rd_i,
  // observed outputs
  input wire logic bus_data_o,
  input wire logic bus_data_oe_o,
  input wire logic synth_ref_6m5_enable_o,
  input wire logic deemphasis_select_o,
  input wire logic mute_o,
  input wire logic wr_done_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // configuration only moves inside a write frame
  property p_ref; $changed(synth_ref_6m5_enable_o) |-> bus_wr_rd_i; endproperty
  a_ref: assert property (p_ref) else $error("reference enable moved outside write");
  property p_dem; $changed(deemphasis_select_o) |-> bus_wr_rd_i; endproperty
  a_dem: assert property (p_dem) else $error("de-emphasis moved outside write");
  property p_mute; $changed(mute_o) |-> bus_wr_rd_i; endproperty
  a_mute: assert property (p_mute) else $error("mute moved outside write");
  // new tuning pulse is single and followed by at least eight low clocks
  property p_done; wr_done_o |=> !wr_done_o [*8]; endproperty
  a_done: assert property (p_done) else $error("tuning pulse too long");
  property p_done_wr; wr_done_o |-> bus_wr_rd_i; endproperty
  a_done_wr: assert property (p_done_wr) else $error("tuning pulse outside write");
  // drive window follows the frame select
  property p_oe_on; $rose(bus_data_oe_o) |-> !$past(bus_wr_rd_i, 3); endproperty
  a_oe_on: assert property (p_oe_on) else $error("drive began without read frame");
  property p_oe_off; $fell(bus_data_oe_o) |-> bus_wr_rd_i; endproperty
  a_oe_off: assert property (p_oe_off) else $error("drive ended inside read frame");
  // read data shifts only while bus clock is low
  property p_shift; bus_data_oe_o && $changed(bus_data_o) |-> !bus_clk_i; endproperty
  a_shift: assert property (p_shift) else $error("read data moved with clock high");
endmodule
bind trb_tuner_regs trb_props chk_u (.sys_clk_i, .rst_n_i, .bus_clk_i, .bus_wr_rd_i, .bus_data_o, .bus_data_oe_o,
  .synth_ref_6m5_enable_o, .deemphasis_select_o, .mute_o, .wr_done_o);
`default_nettype wire
